// *** pwpcs_pkg.sv ***
package pwpcs_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int unsigned CH_NUM  = 6;
  localparam int unsigned CODE_W  = 3;
  localparam int unsigned DIV_W   = 7;

  // ****************************************************************
  // register offsets on the plain register port
  // ****************************************************************
  localparam logic [7:0] OFS_RUN      = 8'h00;
  localparam logic [7:0] OFS_POL      = 8'h01;
  localparam logic [7:0] OFS_CLKSEL   = 8'h02;
  localparam logic [7:0] OFS_PRESCALE = 8'h03;
  localparam logic [7:0] OFS_JOIN     = 8'h05;
  localparam logic [7:0] OFS_LEVEL    = 8'h06;

  // ****************************************************************
  // field positions, masks and reset values
  // ****************************************************************
  localparam int unsigned PRE_A_LSB = 0;
  localparam int unsigned PRE_B_LSB = 4;
  localparam int unsigned JOIN_BIT  = 6;
  localparam logic [7:0] CH_MASK      = 8'h3F;
  localparam logic [7:0] PRE_MASK     = 8'h77;
  localparam logic [7:0] JOIN_MASK    = 8'h40;
  localparam logic [7:0] RST_RUN      = 8'h00;
  localparam logic [7:0] RST_POL      = 8'h00;
  localparam logic [7:0] RST_CLKSEL   = 8'h00;
  localparam logic [7:0] RST_PRESCALE = 8'h00;
  localparam logic [7:0] RST_JOIN     = 8'h00;
  localparam logic [5:0] B_CHANNELS   = 6'h0C;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_OFF  = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN  = 3'b100
  } pwpcs_chan_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pwpcs_bus_req_type;

  typedef struct packed {
    logic [5:0] period_start;
    logic [5:0] duty_match;
    logic       scaled_a;
    logic       scaled_b;
  } pwpcs_evt_type;

  // ****************************************************************
  // functions
  // ****************************************************************
  // divide-by-2^code tick: counter low bits all ones under the mask
  function automatic logic div_tick(input logic [DIV_W-1:0] cnt,
                                    input logic [CODE_W-1:0] code);
    logic [DIV_W:0] mask;
    mask = (8'h01 << code) - 8'h01;
    return ((cnt & mask[DIV_W-1:0]) == mask[DIV_W-1:0]);
  endfunction

  // joined pair takes channel 5 control for channel 4
  function automatic logic [5:0] join_bits(input logic [5:0] bits,
                                           input logic       joined);
    logic [5:0] r;
    r = bits;
    if (joined) begin
      r[4] = bits[5];
    end
    return r;
  endfunction

endpackage

// *** pwpcs_prescaler.sv ***
`timescale 1ns/1ps
module pwpcs_prescaler (
  input  wire logic                         clk_in,
  input  wire logic                         rst_b_in,
  input  wire logic                         clk_en_in,
  input  wire logic                         any_run_in,
  input  wire logic [pwpcs_pkg::CODE_W-1:0] first_divider_code_in,
  input  wire logic [pwpcs_pkg::CODE_W-1:0] second_divider_code_in,
  output logic                              tick_a_out,
  output logic                              tick_b_out
);

  typedef struct packed {
    logic [pwpcs_pkg::DIV_W-1:0] cnt;
  } pwpcs_pre_state_type;

  pwpcs_pre_state_type s_q;
  pwpcs_pre_state_type s_d;

  // free counter, held at zero while no channel runs to save power
  always_comb begin
    s_d = s_q;
    if (!any_run_in) begin
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
    end else if (clk_en_in) begin
      s_q <= s_d;
    end
  end

  // clock a and clock b are independent powers of two of the bus clock
  assign tick_a_out = any_run_in &&
    pwpcs_pkg::div_tick(s_q.cnt, first_divider_code_in); // RULE10
  assign tick_b_out = any_run_in &&
    pwpcs_pkg::div_tick(s_q.cnt, second_divider_code_in); // RULE9

endmodule

// *** pwpcs_top.sv ***
// Overview of operation
// RULE1 - a set start-level bit makes the output high at period start and low at duty match.
// RULE2 - a clear start-level bit makes the output low at period start and high at duty match.
// RULE3 - the polarity register holds six bits, bit n for channel n.
// RULE4 - polarity bits are readable and writable at any time and act at once.
// RULE5 - channels 0, 1, 4 and 5 run on clock A when their source bit is 0, on scaled clock A when 1.
// RULE6 - channels 2 and 3 run on clock B when their source bit is 0, on scaled clock B when 1.
// RULE7 - source bits are writable at any time, even while a waveform runs.
// RULE8 - the prescale register at offset 3 holds clock B code in bits 6..4, clock A code in 2..0, bits 7 and 3 read zero.
// RULE9 - clock B is the bus clock divided by two to the power of its code.
// RULE10 - clock A is the bus clock divided by two to the power of its own code.
// RULE11 - prescale codes are writable at any time while channels run.
// RULE12 - an enabled channel drives its waveform only from the next tick of its selected clock.
// RULE13 - with channels 4 and 5 joined, source and polarity come from the channel 5 bits.
// RULE14 - reset clears all polarity and source bits.
`timescale 1ns/1ps
module pwpcs_top (
  input  wire logic                         clk_in,
  input  wire logic                         rst_b_in,
  input  wire logic                         clk_en_in,
  input  wire pwpcs_pkg::pwpcs_bus_req_type bus_req_in,
  input  wire pwpcs_pkg::pwpcs_evt_type     evt_in,
  output logic [7:0]                        rd_data_out,
  output logic [5:0]                        pwm_out,
  output logic [5:0]                        chan_tick_out,
  output logic                              clk_a_tick_out,
  output logic                              clk_b_tick_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0]                             run;
    logic [7:0]                             pol;
    logic [7:0]                             clksel;
    logic [7:0]                             prescale;
    logic [7:0]                             join_ctl;
    logic [7:0]                             rdata;
    logic [5:0]                             pwm;
    logic [5:0]                             phase;
    logic [5:0]                             chan_tick;
    logic                                   tick_a;
    logic                                   tick_b;
    pwpcs_pkg::pwpcs_chan_state_type [5:0]  st;
  } pwpcs_top_state_type;

  pwpcs_top_state_type s_q;
  pwpcs_top_state_type s_d;

  logic       rst_meta_q;
  logic       rst_sync_q;
  logic       tick_a;
  logic       tick_b;
  logic       joined;
  logic [5:0] run_eff;
  logic [5:0] pol_eff;
  logic [5:0] sel_eff;
  logic [5:0] base_tick;
  logic [5:0] scaled_tick;
  logic [5:0] src_tick;

  // ****************************************************************
  // reset release
  // ****************************************************************
  // asynchronous assert, two-flop release
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ****************************************************************
  // prescaler
  // ****************************************************************
  pwpcs_prescaler u_prescaler (
    .clk_in                 (clk_in),
    .rst_b_in               (rst_sync_q),
    .clk_en_in              (clk_en_in),
    .any_run_in             (|run_eff),
    .first_divider_code_in  (s_q.prescale[pwpcs_pkg::PRE_A_LSB +: 3]),
    .second_divider_code_in (s_q.prescale[pwpcs_pkg::PRE_B_LSB +: 3]),
    .tick_a_out             (tick_a),
    .tick_b_out             (tick_b)
  );

  // ****************************************************************
  // effective per-channel controls
  // ****************************************************************
  // joined pair: channel 4 follows channel 5 bits, its own pin is off
  assign joined  = s_q.join_ctl[pwpcs_pkg::JOIN_BIT];
  assign pol_eff = pwpcs_pkg::join_bits(s_q.pol[5:0], joined); // RULE13
  assign sel_eff = pwpcs_pkg::join_bits(s_q.clksel[5:0], joined); // RULE13
  assign run_eff = s_q.run[5:0] & ~(joined ? 6'h10 : 6'h00);

  // clock a family for 0,1,4,5 and clock b family for 2,3
  always_comb begin
    for (int n = 0; n < pwpcs_pkg::CH_NUM; n++) begin
      if (pwpcs_pkg::B_CHANNELS[n]) begin
        base_tick[n]   = tick_b; // RULE6
        scaled_tick[n] = evt_in.scaled_b;
      end else begin
        base_tick[n]   = tick_a; // RULE5
        scaled_tick[n] = evt_in.scaled_a;
      end
      src_tick[n] = sel_eff[n] ? scaled_tick[n] : base_tick[n]; // RULE7
    end
  end

  // ****************************************************************
  // register port and channel logic
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    // software writes land at once, even mid-period
    if (bus_req_in.wr) begin
      case (bus_req_in.addr)
        pwpcs_pkg::OFS_RUN: begin
          s_d.run = bus_req_in.wdata & pwpcs_pkg::CH_MASK;
        end
        pwpcs_pkg::OFS_POL: begin
          s_d.pol = bus_req_in.wdata & pwpcs_pkg::CH_MASK; // RULE3 RULE4
        end
        pwpcs_pkg::OFS_CLKSEL: begin
          s_d.clksel = bus_req_in.wdata & pwpcs_pkg::CH_MASK; // RULE7
        end
        pwpcs_pkg::OFS_PRESCALE: begin
          s_d.prescale = bus_req_in.wdata & pwpcs_pkg::PRE_MASK; // RULE8 RULE11
        end
        pwpcs_pkg::OFS_JOIN: begin
          s_d.join_ctl = bus_req_in.wdata & pwpcs_pkg::JOIN_MASK;
        end
        default: begin
          s_d.run = s_q.run;
        end
      endcase
    end
    // read data stands only in the cycle after the strobe
    s_d.rdata = 8'h00;
    if (bus_req_in.rd) begin
      case (bus_req_in.addr)
        pwpcs_pkg::OFS_RUN:      s_d.rdata = s_q.run;
        pwpcs_pkg::OFS_POL:      s_d.rdata = s_q.pol; // RULE4
        pwpcs_pkg::OFS_CLKSEL:   s_d.rdata = s_q.clksel;
        pwpcs_pkg::OFS_PRESCALE: s_d.rdata = s_q.prescale; // RULE8
        pwpcs_pkg::OFS_JOIN:     s_d.rdata = s_q.join_ctl;
        pwpcs_pkg::OFS_LEVEL:    s_d.rdata = {2'h0, s_q.pwm};
        default:                 s_d.rdata = 8'h00;
      endcase
    end
    // per-channel sequencing: off, wait for source tick, run
    for (int n = 0; n < pwpcs_pkg::CH_NUM; n++) begin
      case (s_q.st[n])
        pwpcs_pkg::ST_OFF: begin
          s_d.phase[n] = 1'b0;
          if (run_eff[n]) begin
            s_d.st[n] = pwpcs_pkg::ST_WAIT;
          end
        end
        pwpcs_pkg::ST_WAIT: begin
          if (!run_eff[n]) begin
            s_d.st[n] = pwpcs_pkg::ST_OFF;
          end else if (src_tick[n]) begin
            s_d.st[n]    = pwpcs_pkg::ST_RUN; // RULE12
            s_d.phase[n] = 1'b0;
          end
        end
        pwpcs_pkg::ST_RUN: begin
          if (!run_eff[n]) begin
            s_d.st[n] = pwpcs_pkg::ST_OFF;
          end else begin
            // duty match after period start in the same cycle
            if (evt_in.period_start[n]) begin
              s_d.phase[n] = 1'b0;
            end
            if (evt_in.duty_match[n]) begin
              s_d.phase[n] = 1'b1;
            end
          end
        end
        default: begin
          s_d.st[n] = pwpcs_pkg::ST_OFF;
        end
      endcase
      // start level is the polarity bit, flipped after duty match
      if (s_d.st[n] == pwpcs_pkg::ST_RUN) begin
        s_d.pwm[n] = pol_eff[n] ^ s_d.phase[n]; // RULE1 RULE2
      end else begin
        s_d.pwm[n] = 1'b0;
      end
    end
    s_d.chan_tick = src_tick;
    s_d.tick_a    = tick_a;
    s_d.tick_b    = tick_b;
  end

  // reset clears every control bit
  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q          <= '0;
      s_q.run      <= pwpcs_pkg::RST_RUN;
      s_q.pol      <= pwpcs_pkg::RST_POL; // RULE14
      s_q.clksel   <= pwpcs_pkg::RST_CLKSEL; // RULE14
      s_q.prescale <= pwpcs_pkg::RST_PRESCALE;
      s_q.join_ctl <= pwpcs_pkg::RST_JOIN;
      for (int n = 0; n < pwpcs_pkg::CH_NUM; n++) begin
        s_q.st[n] <= pwpcs_pkg::ST_OFF;
      end
    end else if (clk_en_in) begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rd_data_out    = s_q.rdata;
  assign pwm_out        = s_q.pwm;
  assign chan_tick_out  = s_q.chan_tick;
  assign clk_a_tick_out = s_q.tick_a;
  assign clk_b_tick_out = s_q.tick_b;

endmodule

// *** pwpcs_load.sv ***
`timescale 1ns/1ps
// ****************************************************************
// load on the channel pins: counts rising edges seen on channel 0
// ****************************************************************
module pwpcs_load (
  input  wire logic       clk_in,
  input  wire logic [5:0] pwm_in,
  output logic [7:0]      rises_out
);
  logic prev_q = 1'b0;

  initial rises_out = 8'h00;

  // a load only sees levels at the pin, sampled on the bus clock
  always @(posedge clk_in) begin
    if (pwm_in[0] === 1'b1 && prev_q === 1'b0) begin
      rises_out <= rises_out + 8'h01;
    end
    prev_q <= pwm_in[0];
  end
endmodule

// *** pwpcs_chk.sv ***
`timescale 1ns/1ps
module pwpcs_chk (
  input wire logic                         clk_in,
  input wire logic                         rst_b_in,
  input wire pwpcs_pkg::pwpcs_bus_req_type bus_req_in,
  input wire pwpcs_pkg::pwpcs_evt_type     evt_in,
  input wire logic [7:0]                   rd_data_out,
  input wire logic [5:0]                   pwm_out,
  input wire logic [5:0]                   chan_tick_out,
  input wire logic                         clk_a_tick_out,
  input wire logic                         clk_b_tick_out
);
  // ****************************************************************
  // shadow registers, running channels and tick spacing
  // ****************************************************************
  logic [7:0] pol_q, sel_q, pre_q, run_q, ga_q, gb_q, wd;
  logic [5:0] live_q, runp_q, runpp_q;
  logic [1:0] va_q, vb_q;
  logic       wr_pre;

  assign wd = bus_req_in.wdata;
  assign wr_pre = bus_req_in.wr && bus_req_in.addr == pwpcs_pkg::OFS_PRESCALE;

  // live only after a source tick seen with the run bit already set
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {pol_q, sel_q, pre_q, run_q} <= '0;
      {ga_q, gb_q, live_q, runp_q, runpp_q, va_q, vb_q} <= '0;
    end else begin
      if (bus_req_in.wr) begin
        case (bus_req_in.addr)
          pwpcs_pkg::OFS_POL:      pol_q <= wd & pwpcs_pkg::CH_MASK;
          pwpcs_pkg::OFS_CLKSEL:   sel_q <= wd & pwpcs_pkg::CH_MASK;
          pwpcs_pkg::OFS_PRESCALE: pre_q <= wd & pwpcs_pkg::PRE_MASK;
          pwpcs_pkg::OFS_RUN:      run_q <= wd & pwpcs_pkg::CH_MASK;
          default: ;
        endcase
      end
      // a tick only counts once the channel has left its off state
      runp_q  <= run_q[5:0];
      runpp_q <= runp_q;
      live_q  <= run_q[5:0] & (live_q | (chan_tick_out & runpp_q));
      ga_q <= clk_a_tick_out ? 8'h00 : ga_q + 8'h01;
      gb_q <= clk_b_tick_out ? 8'h00 : gb_q + 8'h01;
      // spacing is judged only after three ticks under a steady code
      if (wr_pre || run_q == 8'h00) begin
        va_q <= 2'h0;
        vb_q <= 2'h0;
      end else begin
        if (clk_a_tick_out && va_q != 2'h3) va_q <= va_q + 2'h1;
        if (clk_b_tick_out && vb_q != 2'h3) vb_q <= vb_q + 2'h1;
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence rd_at(logic [7:0] a);
    bus_req_in.rd && bus_req_in.addr == a;
  endsequence

  sequence steady_tick(logic t, logic [1:0] v);
    t && v == 2'h3;
  endsequence

  pol_read_a: assert property (rd_at(pwpcs_pkg::OFS_POL)
    |=> rd_data_out == pol_q) else $error("polarity readback wrong");
  sel_read_a: assert property (rd_at(pwpcs_pkg::OFS_CLKSEL)
    |=> rd_data_out == sel_q) else $error("source readback wrong");
  pre_read_a: assert property (rd_at(pwpcs_pkg::OFS_PRESCALE)
    |=> rd_data_out == pre_q && !rd_data_out[7] && !rd_data_out[3])
    else $error("prescale readback wrong");
  gap_a_a: assert property (steady_tick(clk_a_tick_out, va_q)
    |-> ga_q == (8'h01 << pre_q[2:0]) - 8'h01)
    else $error("clock A tick spacing wrong");
  gap_b_a: assert property (steady_tick(clk_b_tick_out, vb_q)
    |-> gb_q == (8'h01 << pre_q[6:4]) - 8'h01)
    else $error("clock B tick spacing wrong");
  duty_lvl_a: assert property (evt_in.duty_match[0] && live_q[0]
    |=> pwm_out[0] == !$past(pol_q[0])) else $error("duty level wrong");
  start_lvl_a: assert property (evt_in.period_start[0]
    && !evt_in.duty_match[0] && live_q[0]
    |=> pwm_out[0] == $past(pol_q[0])) else $error("start level wrong");
  src_a_a: assert property (sel_q[0] && live_q[0]
    |=> chan_tick_out[0] == $past(evt_in.scaled_a))
    else $error("channel 0 source wrong");
  src_b_a: assert property (sel_q[2] && live_q[2]
    |=> chan_tick_out[2] == $past(evt_in.scaled_b))
    else $error("channel 2 source wrong");
endmodule

bind pwpcs_top pwpcs_chk u_chk (
  .clk_in         (clk_in),
  .rst_b_in       (rst_b_in),
  .bus_req_in     (bus_req_in),
  .evt_in         (evt_in),
  .rd_data_out    (rd_data_out),
  .pwm_out        (pwm_out),
  .chan_tick_out  (chan_tick_out),
  .clk_a_tick_out (clk_a_tick_out),
  .clk_b_tick_out (clk_b_tick_out)
);

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  // ****************************************************************
  // clock, stimulus and counters
  // ****************************************************************
  logic                         clk_in = 1'b0;
  logic                         rst_b;
  pwpcs_pkg::pwpcs_bus_req_type req;
  pwpcs_pkg::pwpcs_evt_type     evt;
  logic [7:0]                   rd_data, rises, r0;
  logic [5:0]                   pwm, ctick;
  logic                         ta, tb_t;
  logic [15:0]                  na = 16'h0000;
  logic [15:0]                  nb = 16'h0000;
  logic [15:0]                  a0, b0;
  logic                         sa_d = 1'b0;
  int                           cyc = 0;
  int                           fails = 0;
  int                           samples_checked = 0;

  always #5 clk_in = ~clk_in;

  pwpcs_top DUT (.clk_in(clk_in), .rst_b_in(rst_b), .clk_en_in(1'b1),
    .bus_req_in(req), .evt_in(evt), .rd_data_out(rd_data),
    .pwm_out(pwm), .chan_tick_out(ctick), .clk_a_tick_out(ta),
    .clk_b_tick_out(tb_t));
  pwpcs_load u_load (.clk_in(clk_in), .pwm_in(pwm), .rises_out(rises));

  // scaled clock A every third cycle, prescaler ticks counted
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    evt.scaled_a <= (cyc % 3 == 0);
    sa_d <= evt.scaled_a;
    if (ta === 1'b1) na <= na + 16'h0001;
    if (tb_t === 1'b1) nb <= nb + 16'h0001;
  end

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one write cycle, then an idle cycle so strobes never collide
  task wr(input logic [7:0] a, input logic [7:0] d);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk_in);
    req.wr <= 1'b0;
    @(posedge clk_in);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_in);
    req.rd <= 1'b0;
    #1 chk(rd_data, e);
    @(posedge clk_in);
  endtask

  task ev(input logic [5:0] ps, input logic [5:0] dm);
    evt.period_start <= ps;
    evt.duty_match <= dm;
    @(posedge clk_in);
    evt.period_start <= 6'h00;
    evt.duty_match <= 6'h00;
  endtask

  task see(input logic [5:0] e);
    #1 chk({2'b00, pwm}, {2'b00, e});
    @(posedge clk_in);
  endtask

  task end_sim;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // watchdog well beyond the expected few thousand cycles
  initial begin
    #200000;
    fails++;
    end_sim;
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    req = '0;
    evt = '0;
    rst_b = 1'b0;
    repeat (6) @(posedge clk_in);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(pwpcs_pkg::OFS_POL, 8'h00);
    rd(pwpcs_pkg::OFS_CLKSEL, 8'h00);
    rd(pwpcs_pkg::OFS_PRESCALE, 8'h00);
    $display("test 1 done");
    wr(pwpcs_pkg::OFS_POL, 8'hFF);
    rd(pwpcs_pkg::OFS_POL, 8'h3F);
    wr(pwpcs_pkg::OFS_CLKSEL, 8'hFF);
    rd(pwpcs_pkg::OFS_CLKSEL, 8'h3F);
    wr(pwpcs_pkg::OFS_PRESCALE, 8'hFF);
    rd(pwpcs_pkg::OFS_PRESCALE, 8'h77);
    $display("test 2 done");
    wr(pwpcs_pkg::OFS_CLKSEL, 8'h00);
    wr(pwpcs_pkg::OFS_POL, 8'h00);
    wr(pwpcs_pkg::OFS_RUN, 8'h05);
    for (int k = 0; k < 8; k++) begin
      wr(pwpcs_pkg::OFS_PRESCALE, {1'b0, 3'(7 - k), 1'b0, 3'(k)});
      repeat (140) @(posedge clk_in);
      a0 = na;
      b0 = nb;
      repeat (128) @(posedge clk_in);
      chk(8'(na - a0), 8'(128 >> k));
      chk(8'(nb - b0), 8'(128 >> (7 - k)));
    end
    $display("test 3 done");
    wr(pwpcs_pkg::OFS_POL, 8'h01);
    see(6'h01);
    ev(6'h00, 6'h01);
    see(6'h00);
    ev(6'h01, 6'h00);
    see(6'h01);
    ev(6'h01, 6'h01);
    see(6'h00);
    r0 = rises;
    wr(pwpcs_pkg::OFS_POL, 8'h00);
    see(6'h01);
    repeat (2) begin
      ev(6'h01, 6'h00);
      see(6'h00);
      ev(6'h00, 6'h01);
      see(6'h01);
    end
    #1 chk(rises - r0, 8'h03);
    @(posedge clk_in);
    $display("test 4 done");
    wr(pwpcs_pkg::OFS_CLKSEL, 8'h04);
    wr(pwpcs_pkg::OFS_POL, 8'h04);
    wr(pwpcs_pkg::OFS_RUN, 8'h00);
    wr(pwpcs_pkg::OFS_RUN, 8'h04);
    repeat (4) @(posedge clk_in);
    see(6'h00);
    evt.scaled_b <= 1'b1;
    @(posedge clk_in);
    evt.scaled_b <= 1'b0;
    repeat (2) @(posedge clk_in);
    see(6'h04);
    $display("test 5 done");
    wr(pwpcs_pkg::OFS_JOIN, 8'h40);
    rd(pwpcs_pkg::OFS_JOIN, 8'h40);
    wr(pwpcs_pkg::OFS_CLKSEL, 8'h21);
    wr(pwpcs_pkg::OFS_POL, 8'h20);
    wr(pwpcs_pkg::OFS_RUN, 8'h31);
    repeat (8) @(posedge clk_in);
    see(6'h20);
    rd(pwpcs_pkg::OFS_LEVEL, 8'h20);
    rd(pwpcs_pkg::OFS_RUN, 8'h31);
    repeat (6) begin
      #1 chk({7'h00, ctick[4]}, {7'h00, sa_d});
      @(posedge clk_in);
    end
    $display("test 6 done");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_in);
    see(6'h00);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(pwpcs_pkg::OFS_POL, 8'h00);
    rd(pwpcs_pkg::OFS_CLKSEL, 8'h00);
    $display("test 7 done");
    end_sim;
  end
endmodule
